/* File: hdl/mcu_exec_subset.sv */
// Execution unit for the watchdog, complement, decimal adjust, step, jump and power-down instructions.
// Assumes an Avalon-MM master on ref_clk; instructions are posted through the command register.
//
// Local design decisions: the Avalon-MM register port and the register offsets.
`default_nettype none
`include "exec_defs.svh"

module mcu_exec_subset
  import exec_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             power_down
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [8:0] bcd_fix(input logic [7:0] v, input logic ac, input logic c);
    logic [4:0] lo;
    logic [4:0] hi;
    logic       c_out;
    lo = {1'b0, v[3:0]};
    if ((v[3:0] > `BCD_LIMIT) || ac) begin
      lo = lo + {1'b0, `BCD_STEP};
    end
    hi = {1'b0, v[7:4]} + {4'h0, lo[4]};
    if ((hi > {1'b0, `BCD_LIMIT}) || c) begin
      hi = hi + {1'b0, `BCD_STEP};
    end
    c_out = c | hi[4];
    return {c_out, hi[3:0], lo[3:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State
  bus_state_e  bus_state_reg, bus_state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wait_reg, wait_next;

  ex_state_e   ex_state_reg, ex_state_next;
  opcode_e     op_reg, op_next;
  logic [7:0]  addr_reg, addr_next;
  logic [2:0]  bit_reg, bit_next;
  logic [12:0] tgt_reg, tgt_next;
  logic [1:0]  cnt_reg, cnt_next;
  logic [7:0]  work_reg, work_next;
  logic [12:0] pc_reg, pc_next;
  logic        c_reg, c_next, ac_reg, ac_next, z_reg, z_next, ov_reg, ov_next;
  logic        pdf_reg, pdf_next, to_reg, to_next;
  logic        arm1_reg, arm1_next, arm2_reg, arm2_next;
  logic        halt_reg, halt_next;
  logic [7:0]  maddr_reg, maddr_next;

  logic [1:0]  phase_reg, phase_next;
  logic [7:0]  presc_reg, presc_next;
  logic [7:0]  wdt_reg, wdt_next;

  logic        mc_en;
  logic        wdt_clear;
  logic        wdt_overflow;
  logic        bus_wr;
  logic [31:0] flags_word;
  logic [31:0] state_word;

  ram_port_if  ram_port ();

  data_ram u_ram (
    .ref_clk (ref_clk),
    .port    (ram_port)
  );

  assign mc_en        = (phase_reg == `MC_LAST_PHASE) && !halt_reg;
  assign wdt_overflow = mc_en && (presc_reg == 8'hFF) && (wdt_reg == 8'hFF);
  assign bus_wr       = (bus_state_reg == BUS_ACK) && avs_write;
  assign flags_word   = {26'h0, to_reg, pdf_reg, ov_reg, z_reg, ac_reg, c_reg};
  assign state_word   = {28'h0, arm2_reg, arm1_reg, halt_reg, (ex_state_reg != EX_IDLE)};

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign power_down      = halt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave
  always_comb begin
    bus_state_next = bus_state_reg;
    rdata_next     = rdata_reg;
    wait_next      = 1'b1;
    case (bus_state_reg)
      BUS_IDLE: begin
        if ((avs_read || avs_write) && (ex_state_reg == EX_IDLE)) begin
          bus_state_next = BUS_WAIT;
        end
      end
      BUS_WAIT: begin
        bus_state_next = BUS_ACK;
        wait_next      = 1'b0;
        rdata_next     = 32'h0000_0000;
        case (avs_address)
          `OFS_WORK:  rdata_next = {24'h0, work_reg};
          `OFS_FLAGS: rdata_next = flags_word;
          `OFS_PC:    rdata_next = {19'h0, pc_reg};
          `OFS_WDT:   rdata_next = {24'h0, wdt_reg};
          `OFS_STATE: rdata_next = state_word;
          `OFS_MADDR: rdata_next = {24'h0, maddr_reg};
          `OFS_MDATA: rdata_next = {24'h0, ram_port.rdata};
          default:    rdata_next = 32'h0000_0000;
        endcase
      end
      BUS_ACK: begin
        bus_state_next = BUS_IDLE;
      end
      default: begin
        bus_state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state_reg <= BUS_IDLE;
      rdata_reg     <= 32'h0000_0000;
      wait_reg      <= 1'b1;
    end else begin
      bus_state_reg <= bus_state_next;
      rdata_reg     <= rdata_next;
      wait_reg      <= wait_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Machine cycle divider and watchdog
  always_comb begin
    phase_next = phase_reg + 2'h1;
    presc_next = presc_reg;
    wdt_next   = wdt_reg;
    if (mc_en) begin
      presc_next = presc_reg + 8'h01;
      if (presc_reg == 8'hFF) begin
        wdt_next = wdt_reg + 8'h01;
      end
    end
    if (halt_reg) begin
      phase_next = phase_reg;
    end
    if (wdt_clear) begin
      wdt_next   = 8'h00;
      presc_next = 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_reg <= 2'h0;
      presc_reg <= `RST_BYTE;
      wdt_reg   <= `RST_BYTE;
    end else begin
      phase_reg <= phase_next;
      presc_reg <= presc_next;
      wdt_reg   <= wdt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction execution and register writes
  always_comb begin
    logic [7:0]  operand;
    logic [7:0]  res;
    logic        mem_wr;
    logic [1:0]  cycles;
    logic [8:0]  daa;
    logic [31:0] wv;
    operand        = (addr_reg == `PCL_ADDR) ? pc_reg[7:0] : ram_port.rdata;
    res            = 8'h00;
    mem_wr         = 1'b0;
    cycles         = `CYC_SINGLE;
    daa            = bcd_fix(work_reg, ac_reg, c_reg);
    wv             = 32'h0000_0000;
    ex_state_next  = ex_state_reg;
    op_next        = op_reg;
    addr_next      = addr_reg;
    bit_next       = bit_reg;
    tgt_next       = tgt_reg;
    cnt_next       = cnt_reg;
    work_next      = work_reg;
    pc_next        = pc_reg;
    c_next         = c_reg;
    ac_next        = ac_reg;
    z_next         = z_reg;
    ov_next        = ov_reg;
    pdf_next       = pdf_reg;
    to_next        = to_reg;
    arm1_next      = arm1_reg;
    arm2_next      = arm2_reg;
    halt_next      = halt_reg;
    maddr_next     = maddr_reg;
    wdt_clear      = 1'b0;
    ram_port.addr  = (ex_state_reg == EX_IDLE) ? maddr_reg : addr_reg;
    ram_port.we    = 1'b0;
    ram_port.wdata = 8'h00;
    case (ex_state_reg)
      EX_IDLE: begin
        if (bus_wr) begin
          case (avs_address)
            `OFS_CMD: begin
              if (!halt_reg) begin
                op_next       = opcode_e'(avs_writedata[`CMD_OP_MSB:`CMD_OP_LSB]);
                addr_next     = avs_writedata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
                bit_next      = avs_writedata[`CMD_BIT_MSB:`CMD_BIT_LSB];
                tgt_next      = avs_writedata[`CMD_TGT_MSB:`CMD_TGT_LSB];
                ex_state_next = EX_FETCH;
              end
            end
            `OFS_WORK: begin
              wv        = be_merge({24'h0, work_reg}, avs_writedata, avs_byteenable);
              work_next = wv[7:0];
            end
            `OFS_FLAGS: begin
              wv      = be_merge(flags_word, avs_writedata, avs_byteenable);
              c_next  = wv[`FLG_C];
              ac_next = wv[`FLG_AC];
              z_next  = wv[`FLG_Z];
              ov_next = wv[`FLG_OV];
            end
            `OFS_PC: begin
              wv      = be_merge({19'h0, pc_reg}, avs_writedata, avs_byteenable);
              pc_next = wv[12:0];
            end
            `OFS_STATE: begin
              if (avs_byteenable[0] && avs_writedata[`ST_WAKE]) begin
                halt_next = 1'b0;
              end
            end
            `OFS_MADDR: begin
              wv         = be_merge({24'h0, maddr_reg}, avs_writedata, avs_byteenable);
              maddr_next = wv[7:0];
            end
            `OFS_MDATA: begin
              ram_port.we    = avs_byteenable[0];
              ram_port.wdata = avs_writedata[7:0];
            end
            default: begin
              wv = 32'h0000_0000;
            end
          endcase
        end
      end
      EX_FETCH: begin
        ex_state_next = EX_EXEC;
      end
      EX_EXEC: begin
        pc_next   = pc_reg + 13'h0001;
        arm1_next = 1'b0;
        arm2_next = 1'b0;
        case (op_reg)
          OP_GUARD_CLEAR: begin
            wdt_clear = 1'b1;
            pdf_next  = 1'b0;
            to_next   = 1'b0;
          end
          OP_PRE_FIRST: begin
            if (arm2_reg) begin
              wdt_clear = 1'b1;
              pdf_next  = 1'b0;
              to_next   = 1'b0;
            end else begin
              arm1_next = 1'b1;
            end
          end
          OP_PRE_SECOND: begin
            if (arm1_reg) begin
              wdt_clear = 1'b1;
              pdf_next  = 1'b0;
              to_next   = 1'b0;
            end else begin
              arm2_next = 1'b1;
            end
          end
          OP_INVERT: begin
            res    = ~operand;
            mem_wr = 1'b1;
            z_next = (res == 8'h00);
          end
          OP_INVERT_WORK: begin
            work_next = ~operand;
            z_next    = (operand == 8'hFF);
          end
          OP_BCD_FIX: begin
            res    = daa[7:0];
            mem_wr = 1'b1;
            c_next = daa[8];
          end
          OP_PLUS_ONE: begin
            res    = operand + 8'h01;
            mem_wr = 1'b1;
            z_next = (res == 8'h00);
          end
          OP_PLUS_ONE_WORK: begin
            work_next = operand + 8'h01;
            z_next    = (operand == 8'hFF);
          end
          OP_MINUS_ONE: begin
            res    = operand - 8'h01;
            mem_wr = 1'b1;
            z_next = (res == 8'h00);
          end
          OP_MINUS_ONE_WK: begin
            work_next = operand - 8'h01;
            z_next    = (operand == 8'h01);
          end
          OP_BRANCH_ABS: begin
            pc_next = tgt_reg;
            cycles  = `CYC_DOUBLE;
          end
          OP_POWER_DOWN: begin
            halt_next = 1'b1;
            wdt_clear = 1'b1;
            pdf_next  = 1'b1;
            to_next   = 1'b0;
          end
          OP_BIT_CLEAR: begin
            res    = operand & ~(8'h01 << bit_reg);
            mem_wr = 1'b1;
          end
          default: begin
            res = 8'h00;
          end
        endcase
        if (mem_wr && (addr_reg == `PCL_ADDR)) begin
          pc_next = {pc_reg[12:8], res};
          cycles  = cycles + 2'h1;
        end else begin
          ram_port.we    = mem_wr;
          ram_port.wdata = res;
        end
        cnt_next      = cycles;
        ex_state_next = EX_WAIT;
      end
      EX_WAIT: begin
        if (mc_en || halt_reg) begin
          cnt_next = cnt_reg - 2'h1;
          if ((cnt_reg == 2'h1) || halt_reg) begin
            ex_state_next = EX_IDLE;
          end
        end
      end
      default: begin
        ex_state_next = EX_IDLE;
      end
    endcase
    if (wdt_overflow) begin
      to_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ex_state_reg <= EX_IDLE;
      op_reg       <= OP_NOP;
      addr_reg     <= `RST_BYTE;
      bit_reg      <= 3'h0;
      tgt_reg      <= `RST_PC;
      cnt_reg      <= 2'h0;
      work_reg     <= `RST_BYTE;
      pc_reg       <= `RST_PC;
      c_reg        <= 1'b0;
      ac_reg       <= 1'b0;
      z_reg        <= 1'b0;
      ov_reg       <= 1'b0;
      pdf_reg      <= 1'b0;
      to_reg       <= 1'b0;
      arm1_reg     <= 1'b0;
      arm2_reg     <= 1'b0;
      halt_reg     <= 1'b0;
      maddr_reg    <= `RST_BYTE;
    end else begin
      ex_state_reg <= ex_state_next;
      op_reg       <= op_next;
      addr_reg     <= addr_next;
      bit_reg      <= bit_next;
      tgt_reg      <= tgt_next;
      cnt_reg      <= cnt_next;
      work_reg     <= work_next;
      pc_reg       <= pc_next;
      c_reg        <= c_next;
      ac_reg       <= ac_next;
      z_reg        <= z_next;
      ov_reg       <= ov_next;
      pdf_reg      <= pdf_next;
      to_reg       <= to_next;
      arm1_reg     <= arm1_next;
      arm2_reg     <= arm2_next;
      halt_reg     <= halt_next;
      maddr_reg    <= maddr_next;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/exec_defs.svh */
// Constants for the instruction execution subset block.
// Assumes inclusion by bare name from the package and the top module.
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH

// Register byte addresses on the Avalon slave
`define OFS_CMD        6'h00
`define OFS_WORK       6'h04
`define OFS_FLAGS      6'h08
`define OFS_PC         6'h0C
`define OFS_WDT        6'h10
`define OFS_STATE      6'h14
`define OFS_MADDR      6'h18
`define OFS_MDATA      6'h1C

// Command word fields
`define CMD_OP_LSB     0
`define CMD_OP_MSB     4
`define CMD_ADDR_LSB   8
`define CMD_ADDR_MSB   15
`define CMD_BIT_LSB    16
`define CMD_BIT_MSB    18
`define CMD_TGT_LSB    19
`define CMD_TGT_MSB    31

// Flag register bit positions
`define FLG_C          0
`define FLG_AC         1
`define FLG_Z          2
`define FLG_OV         3
`define FLG_PDF        4
`define FLG_TO         5

// State register bit positions
`define ST_BUSY        0
`define ST_HALT        1
`define ST_ARM1        2
`define ST_ARM2        3
`define ST_WAKE        1

// Reset values
`define RST_BYTE       8'h00
`define RST_PC         13'h0000

// Data memory
`define RAM_DEPTH      224
`define PCL_ADDR       8'h06

// Timing in system clocks and machine cycles; decimal adjust limit and step
`define MACHINE_CLKS   4
`define MC_LAST_PHASE  2'h3
`define CYC_SINGLE     2'h1
`define CYC_DOUBLE     2'h2
`define BCD_LIMIT      4'h9
`define BCD_STEP       4'h6

`endif

/* File: hdl/exec_pkg.sv */
// Types for the instruction execution subset block.
// Assumes exec_defs.svh is on the include path.
`default_nettype none
package exec_pkg;
  `include "exec_defs.svh"

  typedef enum logic [4:0] {
    OP_NOP           = 5'h00,
    OP_GUARD_CLEAR   = 5'h01,
    OP_PRE_FIRST     = 5'h02,
    OP_PRE_SECOND    = 5'h03,
    OP_INVERT        = 5'h04,
    OP_INVERT_WORK   = 5'h05,
    OP_BCD_FIX       = 5'h06,
    OP_PLUS_ONE      = 5'h07,
    OP_PLUS_ONE_WORK = 5'h08,
    OP_MINUS_ONE     = 5'h09,
    OP_MINUS_ONE_WK  = 5'h0A,
    OP_BRANCH_ABS    = 5'h0B,
    OP_POWER_DOWN    = 5'h0C,
    OP_BIT_CLEAR     = 5'h0D
  } opcode_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_WAIT = 2'h1,
    BUS_ACK  = 2'h2
  } bus_state_e;

  typedef enum logic [1:0] {
    EX_IDLE  = 2'h0,
    EX_FETCH = 2'h1,
    EX_EXEC  = 2'h2,
    EX_WAIT  = 2'h3
  } ex_state_e;
endpackage
`default_nettype wire

/* File: hdl/ram_port_if.sv */
// Single-port data memory connection between the core and its RAM.
// Assumes one clock shared by both ends.
`default_nettype none
interface ram_port_if;
  logic [7:0] addr;
  logic       we;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

/* File: hdl/data_ram.sv */
// Data memory with registered read data.
// Assumes addresses beyond the depth are never used for stored data.
`default_nettype none
`include "exec_defs.svh"
module data_ram
  import exec_pkg::*;
(
  input  wire logic ref_clk,
  ram_port_if.mem   port
);
  logic [7:0] mem_array [`RAM_DEPTH];
  logic [7:0] rdata_reg;
  logic       in_range;

  assign in_range   = (port.addr < 8'(`RAM_DEPTH));
  assign port.rdata = rdata_reg;

  always_ff @(posedge ref_clk) begin
    if (port.we && in_range) begin
      mem_array[port.addr] <= port.wdata;
    end
    rdata_reg <= in_range ? mem_array[port.addr] : 8'h00;
  end
endmodule
`default_nettype wire

/* File: test/mcu_exec_subset_props.sv */
// Checker for the bus handshake and halt behaviour of the execution block.
// Assumes only the top module's ports; attached by the bind at the foot.
`default_nettype none
`include "exec_defs.svh"
module mcu_exec_subset_props
  import exec_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        power_down
);
  logic wr_ack;
  logic rd_ack;
  logic pd_seen_reg;
  logic wake_seen_reg;

  assign wr_ack = !avs_waitrequest && avs_write && avs_byteenable[0];
  assign rd_ack = !avs_waitrequest && avs_read;

  ////////////////////////////////////////////////////////////////////////
  // Remembers accepted halt and wake requests
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pd_seen_reg   <= 1'b0;
      wake_seen_reg <= 1'b0;
    end else begin
      if (power_down)
        pd_seen_reg <= 1'b0;
      else if (wr_ack && avs_address == `OFS_CMD && avs_writedata[4:0] == OP_POWER_DOWN)
        pd_seen_reg <= 1'b1;
      if (!power_down)
        wake_seen_reg <= 1'b0;
      else if (wr_ack && avs_address == `OFS_STATE && avs_writedata[1])
        wake_seen_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_ack_one_cycle:  assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_ack_needs_req:  assert property (!avs_waitrequest |-> (avs_read || avs_write))
    else $error("answer without a request");
  a_ack_not_early:  assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 avs_waitrequest)
    else $error("answer earlier than two cycles");
  a_ack_bounded:    assert property ($rose(avs_read || avs_write) |-> ##[2:40] !avs_waitrequest)
    else $error("request never answered");
  a_rdata_stands:   assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved between answers");
  a_cmd_reads_zero: assert property (rd_ack && avs_address == `OFS_CMD |-> avs_readdata == 32'h0)
    else $error("command register read not zero");
  a_unmapped_zero:  assert property (rd_ack && avs_address[5] |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_halt_cause:     assert property ($rose(power_down) |-> pd_seen_reg)
    else $error("halt without a power-down instruction");
  a_wake_cause:     assert property ($fell(power_down) |-> wake_seen_reg)
    else $error("halt left without a wake write");

  c_halt:  cover property ($rose(power_down));
  c_wake:  cover property ($fell(power_down));
  c_read:  cover property (rd_ack);
endmodule

bind mcu_exec_subset mcu_exec_subset_props props_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_down(power_down));
`default_nettype wire

/* File: test/test_mcu_exec_subset.sv */
// Self-checking bench for the execution block over its register bus.
// Assumes exec_pkg and the checker are compiled ahead of this file.
`default_nettype none
`include "exec_defs.svh"
module test_mcu_exec_subset
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk;
  logic        rst_b;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        power_down;
  int          n_errors;
  int          tests_run;
  int          cyc;
  int          pcl_cyc;
  integer      seed;
  logic [37:0] exp_q[$];
  logic [37:0] note;
  logic [3:0]  ar_e;
  logic        pdf_e;
  logic        to_e;
  opcode_e     ops[8];

  mcu_exec_subset dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .power_down(power_down));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Read answers compared with the oldest note
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      wrap_up();
    end
    if (rst_b === 1'b1 && avs_waitrequest === 1'b0 && avs_read === 1'b1) begin
      note = exp_q.pop_front();
      tests_run++;
      if (avs_readdata !== note[31:0]) begin
        n_errors++;
        $display("[FAIL] reg %h expected %h seen %h", note[37:32], note[31:0], avs_readdata);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon master cycles
  task automatic bus(logic wr_en, logic [5:0] a, logic [31:0] d, logic [3:0] be);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= !wr_en;
    avs_write      <= wr_en;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(logic [5:0] a, logic [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(logic [5:0] a, logic [31:0] e);
    exp_q.push_back({a, e});
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  task automatic op(opcode_e o, logic [7:0] a, logic [2:0] b, logic [12:0] t);
    wr(`OFS_CMD, {t, b, a, 3'h0, o});
  endtask
  task automatic setf();
    ar_e = 4'($random(seed));
    wr(`OFS_FLAGS, {28'h0, ar_e});
  endtask
  function automatic logic [31:0] flg();
    return {26'h0, to_e, pdf_e, ar_e};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // One memory or work instruction on a given memory value with random work, address, counter and flags
  task automatic step(opcode_e o, logic [7:0] v);
    logic [7:0]  a;
    logic [7:0]  w;
    logic [7:0]  r;
    logic [7:0]  m_e;
    logic [7:0]  w_e;
    logic [12:0] p;
    logic [2:0]  b;
    logic [4:0]  lo;
    logic [4:0]  hi;
    a = {2'b01, 6'($random(seed))};
    w = 8'($random(seed));
    p = 13'($random(seed));
    b = 3'($random(seed));
    wr(`OFS_MADDR, {24'h0, a});
    wr(`OFS_MDATA, {24'h0, v});
    wr(`OFS_WORK, {24'h0, w});
    wr(`OFS_PC, {19'h0, p});
    setf();
    m_e = v;
    w_e = w;
    case (o)
      OP_INVERT, OP_INVERT_WORK:     r = ~v;
      OP_PLUS_ONE, OP_PLUS_ONE_WORK: r = v + 8'h01;
      OP_MINUS_ONE, OP_MINUS_ONE_WK: r = v - 8'h01;
      OP_BIT_CLEAR:                  r = v & ~(8'h01 << b);
      default: begin
        lo = {1'b0, w[3:0]} + ((w[3:0] > 4'h9 || ar_e[1]) ? 5'h06 : 5'h00);
        hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09 || ar_e[0]) begin
          hi = hi + 5'h06;
          ar_e[0] = 1'b1;
        end
        r = {hi[3:0], lo[3:0]};
      end
    endcase
    if (!(o inside {OP_BIT_CLEAR, OP_BCD_FIX}))
      ar_e[2] = (r == 8'h00);
    if (o inside {OP_INVERT_WORK, OP_PLUS_ONE_WORK, OP_MINUS_ONE_WK})
      w_e = r;
    else
      m_e = r;
    op(o, a, b, 13'h0);
    rd(`OFS_MDATA, {24'h0, m_e});
    rd(`OFS_WORK, {24'h0, w_e});
    rd(`OFS_FLAGS, flg());
    rd(`OFS_PC, {19'h0, p + 13'h1});
  endtask

  // Power-down with state held across the halt
  task automatic pdown();
    logic [7:0]  v;
    logic [12:0] p;
    v = 8'($random(seed));
    p = 13'($random(seed));
    wr(`OFS_MADDR, 32'h50);
    wr(`OFS_MDATA, {24'h0, v});
    wr(`OFS_WORK, {24'h0, ~v});
    wr(`OFS_PC, {19'h0, p});
    setf();
    op(OP_POWER_DOWN, 8'h00, 3'h0, 13'h0);
    for (int k = 0; k < 60 && power_down !== 1'b1; k++) @(posedge ref_clk);
    tests_run++;
    if (power_down !== 1'b1) begin
      n_errors++;
      $display("[FAIL] power_down expected 1 seen %b", power_down);
    end
    pdf_e = 1'b1;
    to_e  = 1'b0;
    rd(`OFS_PC, {19'h0, p + 13'h1});
    rd(`OFS_WDT, 32'h0);
    rd(`OFS_FLAGS, flg());
    rd(`OFS_MDATA, {24'h0, v});
    rd(`OFS_WORK, {24'h0, ~v});
    op(OP_GUARD_CLEAR, 8'h00, 3'h0, 13'h0);
    rd(`OFS_FLAGS, flg());
    wr(`OFS_STATE, 32'h2);
    rd(`OFS_STATE, 32'h0);
    $display("test power-down done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 77938;
    n_errors = 0;
    tests_run = 0;
    cyc = 0;
    rst_b = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    ar_e = 4'h0;
    pdf_e = 1'b0;
    to_e = 1'b0;
    ops = '{OP_INVERT, OP_INVERT_WORK, OP_BCD_FIX, OP_PLUS_ONE, OP_PLUS_ONE_WORK,
            OP_MINUS_ONE, OP_MINUS_ONE_WK, OP_BIT_CLEAR};
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`OFS_FLAGS, 32'h0);
    rd(`OFS_PC, 32'h0);
    wr(`OFS_WORK, 32'h5A);
    bus(1'b1, `OFS_WORK, 32'hFFFF_FFA5, 4'h2);
    rd(`OFS_WORK, 32'h5A);
    wr(6'h24, 32'hFFFF_FFFF);
    rd(6'h24, 32'h0);
    rd(`OFS_CMD, 32'h0);
    $display("test bus done");
    for (int i = 0; i < 32; i++)
      step(ops[i % 8], (i < 8) ? 8'hFF : (i < 16) ? 8'h01 : (i < 24) ? 8'h00 : 8'($random(seed)));
    $display("test data ops done");
    setf();
    op(OP_BRANCH_ABS, 8'h00, 3'h0, 13'h1ABC);
    rd(`OFS_PC, 32'h1ABC);
    rd(`OFS_FLAGS, flg());
    $display("test branch done");
    wr(`OFS_PC, 32'h0F3A);
    op(OP_PLUS_ONE, `PCL_ADDR, 3'h0, 13'h0);
    pcl_cyc = cyc;
    rd(`OFS_PC, 32'h0F3B);
    pcl_cyc = cyc - pcl_cyc;
    tests_run++;
    if (pcl_cyc < 10 || pcl_cyc > 13) begin
      n_errors++;
      $display("[FAIL] counter-low write cycles expected 10..13 seen %0d", pcl_cyc);
    end
    $display("test counter-low write done");
    pdown();
    repeat (1200) @(posedge ref_clk);
    op(OP_PRE_FIRST, 8'h00, 3'h0, 13'h0);
    rd(`OFS_WDT, 32'h1);
    rd(`OFS_FLAGS, flg());
    op(OP_NOP, 8'h00, 3'h0, 13'h0);
    op(OP_PRE_SECOND, 8'h00, 3'h0, 13'h0);
    rd(`OFS_WDT, 32'h1);
    rd(`OFS_FLAGS, flg());
    op(OP_PRE_FIRST, 8'h00, 3'h0, 13'h0);
    pdf_e = 1'b0;
    rd(`OFS_WDT, 32'h0);
    rd(`OFS_FLAGS, flg());
    $display("test pre-clear done");
    pdown();
    repeat (1200) @(posedge ref_clk);
    setf();
    op(OP_GUARD_CLEAR, 8'h00, 3'h0, 13'h0);
    pdf_e = 1'b0;
    rd(`OFS_WDT, 32'h0);
    rd(`OFS_FLAGS, flg());
    $display("test guard clear done");
    wrap_up();
  end
endmodule
`default_nettype wire
